// ==== rtl/uf_pkg.sv ====
// uf_pkg: constants, register map and carrier types of the uart block
// assumes a 32-bit ahb-lite bus and a 125 MHz hclk used as baud reference
package uf_pkg;
  // ************************************************************
  // fifo geometry
  // ************************************************************
  localparam int UF_DEPTH = 64;
  localparam int UF_AW = 6;
  localparam int UF_CW = 7;
  localparam logic [6:0] UF_FULL_CNT = 7'h40;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] UF_OFF_DATA = 8'h00;
  localparam logic [7:0] UF_OFF_FIFO = 8'h04;
  localparam logic [7:0] UF_OFF_LINE = 8'h08;
  localparam logic [7:0] UF_OFF_DIV = 8'h0C;
  localparam logic [7:0] UF_OFF_EFC = 8'h10;
  localparam logic [7:0] UF_OFF_FTC = 8'h14;
  localparam logic [7:0] UF_OFF_TLP = 8'h18;
  localparam logic [7:0] UF_OFF_STAT = 8'h1C;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int UF_FC_EN = 0;
  localparam int UF_FC_RXCLR = 1;
  localparam int UF_FC_TXCLR = 2;
  localparam int UF_FC_TXSEL = 4;
  localparam int UF_FC_RXSEL = 6;
  localparam int UF_LC_RTS = 1;
  localparam int UF_LC_LOOP = 4;
  localparam int UF_EF_ACTS = 7;
  localparam int UF_EF_ARTS = 6;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] UF_RST_FIFO = 8'h00;
  localparam logic [7:0] UF_RST_LINE = 8'h00;
  localparam logic [15:0] UF_RST_DIV = 16'h0001;
  localparam logic [7:0] UF_RST_EFC = 8'h00;
  localparam logic [7:0] UF_RST_FTC = 8'h00;
  localparam logic [7:0] UF_RST_TLP = 8'h00;
  // ************************************************************
  // timing and trigger choices
  // ************************************************************
  localparam logic [3:0] UF_OVS_LAST = 4'hF;
  localparam logic [3:0] UF_MID = 4'h7;
  localparam logic [2:0] UF_LAST_BIT = 3'h7;
  localparam logic [6:0] UF_TX_TRIG [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  localparam logic [6:0] UF_RX_TRIG [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    UF_IDLE = 2'b00,
    UF_START = 2'b01,
    UF_DATA = 2'b10,
    UF_STOP = 2'b11
  } uf_bit_state_t;
  typedef struct packed {
    logic brk;
    logic frm;
    logic ovr;
    logic [7:0] data;
  } uf_rx_entry_t;
  typedef struct packed {
    logic [7:0] fifo;
    logic [7:0] line;
    logic [15:0] div;
    logic [7:0] efc;
    logic [7:0] ftc;
    logic [7:0] tlp;
  } uf_regs_t;
endpackage

// ==== rtl/uf_fifo.sv ====
// uf_fifo: 64-entry flip-flop fifo with count and synchronous clear
// assumes the caller never relies on push when full or pop when empty
`timescale 1ns/100ps
module uf_fifo import uf_pkg::*; #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [UF_CW-1:0] count
);
  typedef struct packed {
    logic [UF_DEPTH-1:0][W-1:0] mem;
    logic [UF_AW-1:0] wp;
    logic [UF_AW-1:0] rp;
    logic [UF_CW-1:0] cnt;
  } uf_fifo_st_t;

  uf_fifo_st_t s;
  uf_fifo_st_t n;
  logic do_push;
  logic do_pop;

  always_comb begin
    n = s;
    do_push = push && (s.cnt != UF_FULL_CNT);
    do_pop = pop && (s.cnt != '0);
    if (do_push) begin
      n.mem[s.wp] = wdata;
      n.wp = s.wp + 1'b1;
    end
    if (do_pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + UF_CW'(do_push) - UF_CW'(do_pop);
    if (clear) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.mem[s.rp];
  assign count = s.cnt;
endmodule // uf_fifo

// ==== rtl/uf_uart.sv ====
// uf_uart: uart channel with fifos, dma ready pins and hardware flow control
// assumes one ahb-lite master, hclk as baud reference, 8N1 characters
`timescale 1ns/100ps
module uf_uart import uf_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic rts_n,
  output logic tx_space_ready_n,
  output logic rx_data_ready_n
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    uf_regs_t regs;
    logic [7:0] a_addr;
    logic a_wr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [15:0] bcnt;
    logic tick;
    uf_bit_state_t txs;
    logic [3:0] txo;
    logic [2:0] txb;
    logic [7:0] txsh;
    logic txline;
    logic txd;
    uf_bit_state_t rxs;
    logic [3:0] rxo;
    logic [2:0] rxb;
    logic [7:0] rxsh;
    logic rx_ovr;
    logic [1:0] cts_s;
    logic [1:0] rxd_s;
    logic rts_n;
    logic tx_rdy_n;
    logic rx_rdy_n;
  } uf_main_st_t;

  uf_main_st_t s;
  uf_main_st_t n;
  logic tx_push;
  logic tx_pop;
  logic tx_clr;
  logic [7:0] tx_head;
  logic [6:0] tx_cnt;
  logic rx_push;
  logic rx_pop;
  logic rx_clr;
  uf_rx_entry_t rx_entry;
  uf_rx_entry_t rx_head;
  logic [6:0] rx_cnt;
  logic [31:0] rd_val;
  logic fifo_en;
  logic rx_in;
  logic cts_ok;
  logic tx_full;
  logic rx_full;
  logic [15:0] div;
  logic [6:0] tx_trig;
  logic [6:0] rx_trig;
  logic [6:0] tx_free;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;

  // ************************************************************
  // fifos
  // ************************************************************
  uf_fifo #(.W(8)) u_tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(tx_clr),
    .push(tx_push),
    .wdata(hwdata[7:0]),
    .pop(tx_pop),
    .rdata(tx_head),
    .count(tx_cnt)
  );

  uf_fifo #(.W(11)) u_rx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(rx_clr),
    .push(rx_push),
    .wdata(rx_entry),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_cnt)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n = s;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_clr = 1'b0;
    rx_entry = '0;
    rd_val = '0;
    fifo_en = s.regs.fifo[UF_FC_EN];
    // synchronisers
    n.cts_s = {s.cts_s[0], cts_n};
    n.rxd_s = {s.rxd_s[0], rxd};
    rx_in = s.regs.line[UF_LC_LOOP] ? s.txline : s.rxd_s[1];
    cts_ok = !s.regs.efc[UF_EF_ACTS] || !s.cts_s[1];
    tx_full = fifo_en ? (tx_cnt == UF_FULL_CNT) : (tx_cnt != '0);
    rx_full = fifo_en ? (rx_cnt == UF_FULL_CNT) : (rx_cnt != '0);
    tx_free = UF_FULL_CNT - tx_cnt;
    // trigger levels, programmed value wins when nonzero and the fifo is on, both are 1 with the fifo off
    tx_trig = (s.regs.tlp[3:0] != 4'h0) ? {1'b0, s.regs.tlp[3:0], 2'b00}
      : UF_TX_TRIG[s.regs.fifo[UF_FC_TXSEL +: 2]];
    rx_trig = (s.regs.tlp[7:4] != 4'h0) ? {1'b0, s.regs.tlp[7:4], 2'b00}
      : UF_RX_TRIG[s.regs.fifo[UF_FC_RXSEL +: 2]];
    if (!fifo_en) begin
      tx_trig = 7'h01;
      rx_trig = 7'h01;
    end
    halt_lvl = {1'b0, s.regs.ftc[3:0], 2'b00};
    resume_lvl = {1'b0, s.regs.ftc[7:4], 2'b00};

    // baud tick at sixteen times the bit rate
    div = (s.regs.div == 16'h0000) ? 16'h0001 : s.regs.div;
    n.tick = 1'b0;
    if (s.bcnt >= div - 16'h0001) begin
      n.bcnt = '0;
      n.tick = 1'b1;
    end else begin
      n.bcnt = s.bcnt + 16'h0001;
    end

    // ************************************************************
    // register write, data phase
    // ************************************************************
    if (s.a_wr) begin
      unique case (s.a_addr)
        UF_OFF_DATA: begin
          tx_push = !tx_full;
        end
        UF_OFF_FIFO: begin
          n.regs.fifo = hwdata[7:0];
          n.regs.fifo[UF_FC_RXCLR] = 1'b0;
          n.regs.fifo[UF_FC_TXCLR] = 1'b0;
          rx_clr = hwdata[UF_FC_RXCLR] || (hwdata[UF_FC_EN] != fifo_en);
          tx_clr = hwdata[UF_FC_TXCLR] || (hwdata[UF_FC_EN] != fifo_en);
        end
        UF_OFF_LINE: n.regs.line = hwdata[7:0];
        UF_OFF_DIV: n.regs.div = hwdata[15:0];
        UF_OFF_EFC: n.regs.efc = hwdata[7:0];
        UF_OFF_FTC: n.regs.ftc = hwdata[7:0];
        UF_OFF_TLP: n.regs.tlp = hwdata[7:0];
        default: begin
        end
      endcase
    end

    // ************************************************************
    // register read, address phase
    // ************************************************************
    unique case (haddr[7:0])
      UF_OFF_DATA: rd_val = (rx_cnt != '0) ? {21'h000000, rx_head} : 32'h00000000;
      UF_OFF_FIFO: rd_val = {24'h000000, s.regs.fifo};
      UF_OFF_LINE: rd_val = {24'h000000, s.regs.line};
      UF_OFF_DIV: rd_val = {16'h0000, s.regs.div};
      UF_OFF_EFC: rd_val = {24'h000000, s.regs.efc};
      UF_OFF_FTC: rd_val = {24'h000000, s.regs.ftc};
      UF_OFF_TLP: rd_val = {24'h000000, s.regs.tlp};
      UF_OFF_STAT: begin
        rd_val = {7'h00, s.rx_ovr, tx_free >= tx_trig, rx_cnt >= rx_trig,
          s.rxs != UF_IDLE, s.txs != UF_IDLE, !s.cts_s[1], s.rts_n,
          s.tx_rdy_n, s.rx_rdy_n, 1'b0, tx_cnt, 1'b0, rx_cnt};
      end
      default: rd_val = 32'h00000000;
    endcase
    n.a_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.a_addr = haddr[7:0];
      n.a_wr = hwrite;
      if (!hwrite) begin
        n.hrdata = rd_val;
        rx_pop = (haddr[7:0] == UF_OFF_DATA) && (rx_cnt != '0);
      end
    end
    n.hreadyout = 1'b1;

    // ************************************************************
    // transmitter
    // ************************************************************
    if (s.tick) begin
      unique case (s.txs)
        UF_IDLE: begin
          if (tx_cnt != '0 && cts_ok) begin
            tx_pop = 1'b1;
            n.txsh = tx_head;
            n.txline = 1'b0;
            n.txo = '0;
            n.txs = UF_START;
          end
        end
        UF_START: begin
          n.txo = s.txo + 4'h1;
          if (s.txo == UF_OVS_LAST) begin
            n.txline = s.txsh[0];
            n.txb = '0;
            n.txs = UF_DATA;
          end
        end
        UF_DATA: begin
          n.txo = s.txo + 4'h1;
          if (s.txo == UF_OVS_LAST) begin
            n.txsh = {1'b0, s.txsh[7:1]};
            n.txb = s.txb + 3'h1;
            n.txline = s.txsh[1];
            if (s.txb == UF_LAST_BIT) begin
              n.txline = 1'b1;
              n.txs = UF_STOP;
            end
          end
        end
        UF_STOP: begin
          n.txo = s.txo + 4'h1;
          if (s.txo == UF_OVS_LAST) begin
            n.txs = UF_IDLE;
          end
        end
      endcase
    end
    n.txd = n.regs.line[UF_LC_LOOP] ? 1'b1 : n.txline;

    // ************************************************************
    // receiver
    // ************************************************************
    if (s.tick) begin
      unique case (s.rxs)
        UF_IDLE: begin
          if (!rx_in) begin
            n.rxo = '0;
            n.rxs = UF_START;
          end
        end
        UF_START: begin
          n.rxo = s.rxo + 4'h1;
          if (s.rxo == UF_MID) begin
            n.rxo = '0;
            n.rxb = '0;
            n.rxs = rx_in ? UF_IDLE : UF_DATA;
          end
        end
        UF_DATA: begin
          n.rxo = s.rxo + 4'h1;
          if (s.rxo == UF_OVS_LAST) begin
            n.rxsh = {rx_in, s.rxsh[7:1]};
            n.rxb = s.rxb + 3'h1;
            if (s.rxb == UF_LAST_BIT) begin
              n.rxs = UF_STOP;
            end
          end
        end
        UF_STOP: begin
          n.rxo = s.rxo + 4'h1;
          if (s.rxo == UF_OVS_LAST) begin
            n.rxs = UF_IDLE;
            rx_entry.data = s.rxsh;
            rx_entry.frm = !rx_in;
            rx_entry.brk = !rx_in && (s.rxsh == 8'h00);
            rx_entry.ovr = s.rx_ovr;
            if (rx_full) begin
              n.rx_ovr = 1'b1;
            end else begin
              rx_push = 1'b1;
              n.rx_ovr = 1'b0;
            end
          end
        end
      endcase
    end

    // ************************************************************
    // ready pins and request to send
    // ************************************************************
    if (!fifo_en) begin
      n.tx_rdy_n = (tx_cnt != '0);
    end else if (tx_cnt == '0 || tx_free >= tx_trig) begin
      n.tx_rdy_n = 1'b0;
    end else if (tx_cnt == UF_FULL_CNT) begin
      n.tx_rdy_n = 1'b1;
    end
    if (rx_cnt >= rx_trig || rx_cnt != '0) begin
      n.rx_rdy_n = 1'b0;
    end else begin
      n.rx_rdy_n = 1'b1;
    end
    if (s.regs.efc[UF_EF_ARTS]) begin
      if (rx_cnt >= halt_lvl) begin
        n.rts_n = 1'b1;
      end else if (rx_cnt <= resume_lvl) begin
        n.rts_n = 1'b0;
      end
    end else begin
      n.rts_n = !s.regs.line[UF_LC_RTS];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.regs.fifo <= UF_RST_FIFO;
      s.regs.line <= UF_RST_LINE;
      s.regs.div <= UF_RST_DIV;
      s.regs.efc <= UF_RST_EFC;
      s.regs.ftc <= UF_RST_FTC;
      s.regs.tlp <= UF_RST_TLP;
      s.hreadyout <= 1'b1;
      s.txline <= 1'b1;
      s.txd <= 1'b1;
      s.cts_s <= 2'h3;
      s.rxd_s <= 2'h3;
      s.rts_n <= 1'b1;
      s.tx_rdy_n <= 1'b1;
      s.rx_rdy_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign txd = s.txd;
  assign rts_n = s.rts_n;
  assign tx_space_ready_n = s.tx_rdy_n;
  assign rx_data_ready_n = s.rx_rdy_n;
endmodule // uf_uart

// ==== testbench/uf_uart_checker.sv ====
// uf_uart_checker: port-level assertions for uf_uart
// assumes hready tied to hreadyout and a baud divisor of at least one
`timescale 1ns/100ps
module uf_uart_checker import uf_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic tx_space_ready_n,
  input wire logic rx_data_ready_n
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_reset_idle;
    $rose(hresetn) |-> $past(txd) && $past(rts_n) && $past(tx_space_ready_n)
      && $past(rx_data_ready_n);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
  property p_ready_after_reset;
    $rose(hresetn) |=> !tx_space_ready_n && rx_data_ready_n;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) else $error("bad ready pins");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not okay");
  property p_start_len;
    $fell(txd) |-> !txd [*8] ##1 !txd [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
  property p_mark_len;
    $rose(txd) |-> txd [*8] ##1 txd [*8];
  endproperty
  a_mark_len: assert property (p_mark_len) else $error("high bit too short");
  property p_rdata_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped_zero;
    hsel && hready && htrans[1] && !hwrite && haddr[7:5] != 3'h0 |=> hrdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");
  property p_data_width;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == UF_OFF_DATA
      |=> hrdata[31:11] == 21'h0;
  endproperty
  a_data_width: assert property (p_data_width) else $error("rx word too wide");
endmodule // uf_uart_checker
bind uf_uart uf_uart_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
  .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .tx_space_ready_n(tx_space_ready_n),
  .rx_data_ready_n(rx_data_ready_n));

// ==== testbench/uf_remote_model.sv ====
// uf_remote_model: remote 8N1 uart on the serial side
// assumes the bench sets div equal to the device divisor
`timescale 1ns/100ps
module uf_remote_model (
  input wire logic hclk,
  input wire logic [15:0] div,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic obey_rts,
  input wire logic stall,
  output logic rxd,
  output logic cts_n,
  output logic got,
  output logic [7:0] got_byte
);
  logic [8:0] send_q[$];
  logic [8:0] cur;
  logic busy;
  int bt;
  assign bt = 16 * int'(div);
  // ****************************************
  // sender: {stop, data}, lsb first
  // ****************************************
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      wait (send_q.size() > 0);
      busy = 1'b1;
      cur = send_q.pop_front();
      repeat (2 * bt) @(posedge hclk);
      while (obey_rts && rts_n !== 1'b0) @(posedge hclk);
      rxd <= 1'b0;
      repeat (bt) @(posedge hclk);
      for (int i = 0; i < 9; i++) begin
        rxd <= cur[i];
        repeat (bt) @(posedge hclk);
      end
      rxd <= 1'b1;
      busy = 1'b0;
    end
  end
  // ****************************************
  // receiver and clear to send
  // ****************************************
  initial begin
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (bt / 2) @(posedge hclk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bt) @(posedge hclk);
          got_byte[i] <= txd;
        end
        repeat (bt) @(posedge hclk);
        got <= 1'b1;
        @(posedge hclk);
        got <= 1'b0;
      end
    end
  end
  // bench moves stall only between characters
  always @(posedge hclk) cts_n <= stall;
endmodule // uf_remote_model

// ==== testbench/test_uart_fifo_hw_flow_control.sv ====
// test_uart_fifo_hw_flow_control: self-checking bench for uf_uart
// assumes uf_remote_model on the serial side and the bound checker
`timescale 1ns/100ps
`define UF_CHK(g, x) begin n_tests++; if ((g) !== (x)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module test_uart_fifo_hw_flow_control import uf_pkg::*; ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, rd_live, obey_rts, stall, txd, rts_n, hreadyout, hresp, rxd, cts_n;
  logic got, tx_space_ready_n, rx_data_ready_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, e, m;
  logic [15:0] div;
  logic [7:0] b, got_byte, e8;
  logic [10:0] rxq[$];
  logic [31:0] exp_rd[$], exp_mask[$];
  logic [7:0] exp_ser[$];
  int n_errors = 0;
  int n_tests = 0;
  int k;
  always #4 hclk = ~hclk;
  uf_uart dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .cts_n(cts_n), .txd(txd),
    .rts_n(rts_n), .tx_space_ready_n(tx_space_ready_n), .rx_data_ready_n(rx_data_ready_n));
  uf_remote_model remote_u (.hclk(hclk), .div(div), .txd(txd), .rts_n(rts_n),
    .obey_rts(obey_rts), .stall(stall), .rxd(rxd), .cts_n(cts_n), .got(got),
    .got_byte(got_byte));
  // ****************************************
  // monitors
  // ****************************************
  always @(posedge hclk) if (rd_live === 1'b1) begin
    m = exp_mask.pop_front();
    e = exp_rd.pop_front();
    `UF_CHK(hrdata & m, e)
  end
  always @(posedge got) begin
    e8 = exp_ser.pop_front();
    `UF_CHK(got_byte, e8)
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_live <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_live <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
    exp_rd.push_back(x & mk);
    exp_mask.push_back(mk);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic stat(input logic [6:0] rxc, input logic [6:0] txc, input logic [2:0] pins);
    rd(UF_OFF_STAT, {13'h0, pins, 1'b0, txc, 1'b0, rxc}, 32'h00077F7F);
  endtask
  task automatic settle();
    k = 0;
    while ((exp_ser.size() != 0 || remote_u.send_q.size() != 0 || remote_u.busy)
        && k < 20000) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 20000) begin
      n_errors++;
      $display("wrong value at %0t: serial side never settled", $time);
    end
    repeat (60) @(posedge hclk);
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge hclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    rd_live = 1'b0; div = 16'h0001; obey_rts = 1'b0; stall = 1'b0;
    b = 8'($urandom(32'h94E8027D));
    repeat (4) @(posedge hclk);
    `UF_CHK({txd, rts_n, tx_space_ready_n, rx_data_ready_n}, 4'hF)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    stat(7'h00, 7'h00, 3'b101);
    rd(UF_OFF_FIFO, {24'h0, UF_RST_FIFO}, 32'hFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(UF_OFF_DIV, 32'h3);
    div <= 16'h0003;
    rd(UF_OFF_DIV, 32'h3, 32'hFFFF);
    b = 8'($urandom);
    exp_ser.push_back(b);
    wr(UF_OFF_DATA, {24'h0, b});
    settle();
    wr(UF_OFF_DIV, 32'h1);
    div <= 16'h0001;
    // holding byte waits for clear to send
    wr(UF_OFF_EFC, 32'h80);
    stall <= 1'b1;
    repeat (5) @(posedge hclk);
    b = 8'($urandom);
    exp_ser.push_back(b);
    wr(UF_OFF_DATA, {24'h0, b});
    wr(UF_OFF_DATA, {24'h0, ~b});
    repeat (100) @(posedge hclk);
    `UF_CHK({txd, tx_space_ready_n}, 2'b11)
    stall <= 1'b0;
    settle();
    // fill the transmit fifo while stalled
    wr(UF_OFF_FIFO, 32'h01);
    stall <= 1'b1;
    repeat (5) @(posedge hclk);
    for (int i = 0; i < 65; i++) begin
      b = 8'($urandom);
      if (i < 64) exp_ser.push_back(b);
      wr(UF_OFF_DATA, {24'h0, b});
    end
    stat(7'h00, 7'h40, 3'b111);
    `UF_CHK(txd, 1'b1)
    stall <= 1'b0;
    settle();
    stat(7'h00, 7'h00, 3'b101);
    // receive under auto request to send, halt 8 resume 4
    wr(UF_OFF_EFC, 32'h40);
    wr(UF_OFF_FTC, 32'h12);
    repeat (2) @(posedge hclk);
    `UF_CHK(rts_n, 1'b0)
    obey_rts <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      b = 8'($urandom) | 8'h01;
      rxq.push_back({1'b0, i == 0, 1'b0, b});
      remote_u.send_q.push_back({i != 0, b});
    end
    k = 0;
    while (rts_n !== 1'b1 && k < 5000) begin
      @(posedge hclk);
      k++;
    end
    repeat (300) @(posedge hclk);
    stat(7'h08, 7'h00, 3'b100);
    // rx trigger: select gives 8, programmed 12
    rd(UF_OFF_STAT, 32'h00400000, 32'h00400000);
    wr(UF_OFF_TLP, 32'h30);
    rd(UF_OFF_STAT, 32'h00000000, 32'h00400000);
    wr(UF_OFF_TLP, 32'h0);
    for (int i = 0; i < 4; i++) rd(UF_OFF_DATA, 32'(rxq.pop_front()), 32'h7FF);
    repeat (3) @(posedge hclk);
    `UF_CHK(rts_n, 1'b0)
    settle();
    stat(7'h08, 7'h00, 3'b100);
    for (int i = 0; i < 8; i++) rd(UF_OFF_DATA, 32'(rxq.pop_front()), 32'h7FF);
    stat(7'h00, 7'h00, 3'b001);
    // loopback with garbage on the external pin
    obey_rts <= 1'b0;
    wr(UF_OFF_LINE, 32'h10);
    remote_u.send_q.push_back(9'h000);
    b = 8'($urandom);
    wr(UF_OFF_DATA, {24'h0, b});
    repeat (100) @(posedge hclk);
    `UF_CHK(txd, 1'b1)
    settle();
    repeat (200) @(posedge hclk);
    rd(UF_OFF_DATA, {24'h0, b}, 32'h7FF);
    stat(7'h00, 7'h00, 3'b001);
    end_sim();
  end
endmodule // test_uart_fifo_hw_flow_control
